/* File: hw/seq_pkg.sv */
// ==========================================
// Shared constants and types
package seq_pkg;
   localparam int          NUM_DP         = 8;
   // Register offsets (word addresses on the plain port)
   localparam logic [7:0]  OFS_CONTROL    = 8'h00;
   localparam logic [7:0]  OFS_DEINIT     = 8'h01;
   localparam logic [7:0]  OFS_TX_CTRL    = 8'h02;
   localparam logic [7:0]  OFS_MOD_FLAGS  = 8'h03;
   localparam logic [7:0]  OFS_DP_FLAGS   = 8'h04;
   localparam logic [7:0]  OFS_MOD_MASK   = 8'h05;
   localparam logic [7:0]  OFS_DP_MASK    = 8'h06;
   localparam logic [7:0]  OFS_STATE      = 8'h07;
   localparam logic [7:0]  OFS_ACTIVE_CFG = 8'h08;
   localparam logic [7:0]  OFS_STAGED_CFG = 8'h09;
   // Control register field positions
   localparam int          BIT_SW_LP      = 0;
   localparam int          BIT_HW_ALLOW   = 1;
   // Power-on defaults
   localparam logic [7:0]  RST_CONTROL    = 8'h0002;
   localparam logic [7:0]  RST_DEINIT     = 8'h0000;
   localparam logic [7:0]  RST_TX_CTRL    = 8'h0000;
   localparam logic [7:0]  RST_MASK       = 8'h0000;
   localparam logic [7:0]  DEFAULT_CFG    = 8'h0001;
   // Step times
   localparam int          CLK_MHZ        = 200;
   localparam int          SETUP_NS       = 100;
   localparam int          PWRUP_NS       = 200;
   localparam int          DP_STATE_SETTING_UP_NS      = 100;
   localparam int          TXON_NS        = 50;
   localparam logic [7:0]  SETUP_CYC      = 8'((SETUP_NS * CLK_MHZ + 999) / 1000);
   localparam logic [7:0]  PWRUP_CYC      = 8'((PWRUP_NS * CLK_MHZ + 999) / 1000);
   localparam logic [7:0]  DP_STATE_SETTING_UP_CYC     = 8'((DP_STATE_SETTING_UP_NS * CLK_MHZ + 999) / 1000);
   localparam logic [7:0]  TXON_CYC       = 8'((TXON_NS * CLK_MHZ + 999) / 1000);

   typedef enum logic [1:0] {
      state_mgmt_setup, state_low_power, state_powering_up, state_operational
   } mod_state_t;
   typedef enum logic [2:0] {
      dp_state_off, dp_state_setting_up, dp_state_prepared, dp_state_tx_enabling, dp_state_on
   } dp_state_t;
endpackage : seq_pkg

/* File: hw/evt_if.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Event strobes from sequencer into flag block
interface evt_if;
   logic       mod_evt;
   logic [7:0] dp_evt;
   modport src (output mod_evt, output dp_evt);
   modport dst (input mod_evt, input dp_evt);
endinterface : evt_if
`default_nettype wire

/* File: hw/flag_block.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Sticky state change flags, mask, interrupt
module flag_block
   import seq_pkg::*;
(
   input  wire logic       mclk_in,
   input  wire logic       rst_in,
   evt_if.dst              evt,
   input  wire logic       mod_clr_in,
   input  wire logic [7:0] dp_clr_in,
   input  wire logic       mod_mask_in,
   input  wire logic [7:0] dp_mask_in,
   output logic            mod_flag_out,
   output logic      [7:0] dp_flag_out,
   output logic            irq_out
);
   typedef struct packed {
      logic       mod_flag;
      logic [7:0] dp_flag;
   } flag_state_t;
   flag_state_t s_r, s_nxt;

   // Set wins over clear
   always_comb begin
      s_nxt = s_r;
      s_nxt.mod_flag = evt.mod_evt | (s_r.mod_flag & ~mod_clr_in);
      s_nxt.dp_flag  = evt.dp_evt | (s_r.dp_flag & ~dp_clr_in);
   end

   always_ff @(posedge mclk_in) begin
      if (rst_in) s_r <= '0;
      else        s_r <= s_nxt;
   end

   assign mod_flag_out = s_r.mod_flag;
   assign dp_flag_out  = s_r.dp_flag;
   // Level interrupt while any unmasked flag stands
   assign irq_out = (s_r.mod_flag & ~mod_mask_in) | (|(s_r.dp_flag & ~dp_mask_in)); // see R13 R17

   a_flag_holds: assert property (@(posedge mclk_in) disable iff (rst_in) // see R17
      s_r.mod_flag && !mod_clr_in |=> s_r.mod_flag)
      else $error("module flag lost without clear");
   a_event_sets: assert property (@(posedge mclk_in) disable iff (rst_in) // see R7
      evt.mod_evt |=> s_r.mod_flag)
      else $error("module event not latched");
endmodule : flag_block
`default_nettype wire

/* File: hw/module_hw_init_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
// Function
// R1: Low-power stop or pass-through follows the sw request, the hw allow and hw_low_power_pin.
// R2: With allow at 1 the host holds hw_low_power_pin high to get software-controlled start-up.
// R3: Setup loads defaults: sw request 0, allow 1, deinit mask 00h, tx disable and squelch 0.
// R4: At power-up the default data path configuration is copied into active and staged set 0.
// R5: In low power with the transition condition false the module moves straight to powering up.
// R6: Powering up raises high power mode before ready, data paths staying off.
// R7: The module state change flag is set on entry into ready.
// R8: In ready with deinit condition false every data path goes from off to setting up.
// R9: Setting up configures each data path from the active set, then enters prepared.
// R10: From prepared with deactivate condition false all data paths go to tx enabling.
// R11: Tx enabling turns on the transmit outputs, then enters on.
// R12: Entry into on sets each data path state change flag, then the module waits.
// R13: The interrupt rises on set flags and a host read of the flags drops it.
// R14: The host releases the low-power pin, selects the module and releases reset before hot plug.
// R15: The host sends valid signal for the default application before plug-in.
// R16: The host waits for the second interrupt before carrying traffic.
// R17: The interrupt stays asserted while any flag is uncleared; a flag clears only on read. The code drops the interrupt while the uncleared flag is masked.
module module_hw_init_sequencer
   import seq_pkg::*;
(
   input  wire logic        mclk_in,
   input  wire logic        rst_in,
   input  wire logic        hw_low_power_pin_in,
   input  wire logic        module_select_pin_in,
   input  wire logic [7:0]  addr_in,
   input  wire logic [7:0]  wdata_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic      [7:0]  rdata_out,
   output logic             irq_out,
   output logic             high_power_out,
   output logic      [7:0]  tx_enable_out,
   output logic      [7:0]  tx_squelch_out
);
   // ==========================================
   // State
   typedef struct packed {
      mod_state_t            mst;
      dp_state_t [NUM_DP-1:0] dst;
      logic [7:0]            cnt;
      logic                  sw_lp;
      logic                  hw_allow;
      logic [7:0]            deinit_mask;
      logic                  tx_disable;
      logic                  squelch;
      logic [7:0]            active_cfg;
      logic [7:0]            staged_cfg;
      logic [7:0]            dp_cfg;
      logic                  hp;
      logic [7:0]            tx_en;
      logic                  mod_mask;
      logic [7:0]            dp_mask;
      logic [7:0]            rdata;
   } seq_state_t;
   seq_state_t s_r, s_nxt;

   evt_if ev ();
   logic       mod_flag;
   logic [7:0] dp_flag;
   logic       mod_clr;
   logic [7:0] dp_clr;
   logic       lp_cond;
   logic       dp_deinit_cond_w;
   logic       dp_deactivate_cond;
   logic       all_prepared;
   logic       all_setting;
   logic       all_enabling;
   logic [7:0] dp_enter_on;

   // ==========================================
   // Transition conditions
   assign lp_cond = s_r.sw_lp | (s_r.hw_allow & hw_low_power_pin_in); // see R1
   assign dp_deinit_cond_w   = lp_cond;
   assign dp_deactivate_cond = lp_cond | s_r.tx_disable;

   // Data path group status
   always_comb begin
      all_prepared = 1'b1;
      all_setting  = 1'b1;
      all_enabling = 1'b1;
      for (int i = 0; i < NUM_DP; i++) begin
         all_prepared &= (s_r.dst[i] == dp_state_prepared);
         all_setting  &= (s_r.dst[i] == dp_state_setting_up);
         all_enabling &= (s_r.dst[i] == dp_state_tx_enabling);
      end
   end

   // Flag clears on read of the flag registers
   assign mod_clr = rd_in && (addr_in == OFS_MOD_FLAGS); // see R13
   assign dp_clr  = (rd_in && (addr_in == OFS_DP_FLAGS)) ? 8'hFF : 8'h00;

   // ==========================================
   // Next state
   always_comb begin
      s_nxt = s_r;
      ev.mod_evt  = 1'b0;
      dp_enter_on = 8'h00;
      if (s_r.cnt != 8'h00) s_nxt.cnt = s_r.cnt - 8'd1;
      unique case (s_r.mst)
         state_mgmt_setup: begin
            s_nxt.sw_lp       = RST_CONTROL[BIT_SW_LP];      // see R3
            s_nxt.hw_allow    = RST_CONTROL[BIT_HW_ALLOW];
            s_nxt.deinit_mask = RST_DEINIT;
            s_nxt.tx_disable  = RST_TX_CTRL[0];
            s_nxt.squelch     = RST_TX_CTRL[1];
            s_nxt.active_cfg  = DEFAULT_CFG;                 // see R4
            s_nxt.staged_cfg  = DEFAULT_CFG;
            if (s_r.cnt == 8'h00) s_nxt.mst = state_low_power;
         end
         state_low_power: begin
            s_nxt.hp = 1'b0;
            if (!lp_cond) begin                              // see R5
               s_nxt.mst = state_powering_up;
               s_nxt.cnt = PWRUP_CYC;
            end
         end
         state_powering_up: begin
            s_nxt.hp = 1'b1;                                 // see R6
            if (s_r.cnt == 8'h00) begin
               s_nxt.mst  = state_operational;
               ev.mod_evt = 1'b1;                            // see R7
            end
         end
         state_operational: begin
            if (lp_cond && (s_r.dst == '0)) begin
               s_nxt.mst = state_low_power;
               ev.mod_evt = 1'b1;
            end
         end
      endcase
      // Data path machines, lock-step across all paths
      for (int i = 0; i < NUM_DP; i++) begin
         unique case (s_r.dst[i])
            dp_state_off:
               if (s_r.mst == state_operational && !dp_deinit_cond_w
                   && !s_r.deinit_mask[i]) begin
                  s_nxt.dst[i] = dp_state_setting_up;       // see R8
                  s_nxt.cnt    = DP_STATE_SETTING_UP_CYC;
               end
            dp_state_setting_up:
               if (dp_deinit_cond_w || s_r.deinit_mask[i])
                  s_nxt.dst[i] = dp_state_off;
               else if (s_r.cnt == 8'h00 && all_setting) begin
                  s_nxt.dp_cfg = s_r.active_cfg;            // see R9
                  s_nxt.dst[i] = dp_state_prepared;
               end
            dp_state_prepared:
               if (dp_deinit_cond_w || s_r.deinit_mask[i])
                  s_nxt.dst[i] = dp_state_off;
               else if (!dp_deactivate_cond && all_prepared) begin
                  s_nxt.dst[i] = dp_state_tx_enabling;      // see R10
                  s_nxt.cnt    = TXON_CYC;
               end
            dp_state_tx_enabling: begin
               s_nxt.tx_en[i] = 1'b1;                       // see R11
               if (s_r.cnt == 8'h00 && all_enabling) begin
                  s_nxt.dst[i]   = dp_state_on;
                  dp_enter_on[i] = 1'b1;                    // see R12
               end
            end
            dp_state_on:
               if (dp_deactivate_cond || s_r.deinit_mask[i]) begin
                  s_nxt.tx_en[i] = 1'b0;
                  s_nxt.dst[i]   = dp_state_prepared;
               end
            default: s_nxt.dst[i] = dp_state_off;
         endcase
      end
      // Register writes
      if (wr_in) begin
         unique case (addr_in)
            OFS_CONTROL: begin
               s_nxt.sw_lp    = wdata_in[BIT_SW_LP];
               s_nxt.hw_allow = wdata_in[BIT_HW_ALLOW];
            end
            OFS_DEINIT:     s_nxt.deinit_mask = wdata_in;
            OFS_TX_CTRL: begin
               s_nxt.tx_disable = wdata_in[0];
               s_nxt.squelch    = wdata_in[1];
            end
            OFS_MOD_MASK:   s_nxt.mod_mask   = wdata_in[0];
            OFS_DP_MASK:    s_nxt.dp_mask    = wdata_in;
            OFS_STAGED_CFG: s_nxt.staged_cfg = wdata_in;
            default: ;
         endcase
      end
      // Register reads, data one cycle later
      s_nxt.rdata = 8'h00;
      if (rd_in) begin
         unique case (addr_in)
            OFS_CONTROL:    s_nxt.rdata = {6'd0, s_r.hw_allow, s_r.sw_lp};
            OFS_DEINIT:     s_nxt.rdata = s_r.deinit_mask;
            OFS_TX_CTRL:    s_nxt.rdata = {6'd0, s_r.squelch, s_r.tx_disable};
            OFS_MOD_FLAGS:  s_nxt.rdata = {7'd0, mod_flag};
            OFS_DP_FLAGS:   s_nxt.rdata = dp_flag;
            OFS_MOD_MASK:   s_nxt.rdata = {7'd0, s_r.mod_mask};
            OFS_DP_MASK:    s_nxt.rdata = s_r.dp_mask;
            OFS_STATE:      s_nxt.rdata = {3'd0, s_r.dst[0], s_r.mst};
            OFS_ACTIVE_CFG: s_nxt.rdata = s_r.active_cfg;
            OFS_STAGED_CFG: s_nxt.rdata = s_r.staged_cfg;
            default:        s_nxt.rdata = 8'h00;
         endcase
      end
   end
   assign ev.dp_evt = dp_enter_on;

   // ==========================================
   // State register
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         s_r             <= '0;
         s_r.mst         <= state_mgmt_setup;
         s_r.cnt         <= SETUP_CYC;
         s_r.hw_allow    <= 1'b1;
         s_r.mod_mask    <= RST_MASK[0];
         s_r.dp_mask     <= RST_MASK;
      end else begin
         s_r <= s_nxt;
      end
   end

   flag_block u_flags (
      .mclk_in      (mclk_in),
      .rst_in       (rst_in),
      .evt          (ev.dst),
      .mod_clr_in   (mod_clr),
      .dp_clr_in    (dp_clr),
      .mod_mask_in  (s_r.mod_mask),
      .dp_mask_in   (s_r.dp_mask),
      .mod_flag_out (mod_flag),
      .dp_flag_out  (dp_flag),
      .irq_out      (irq_out)
   );

   assign rdata_out      = s_r.rdata;
   assign high_power_out = s_r.hp;
   assign tx_enable_out  = s_r.tx_en & {8{~s_r.tx_disable}};
   assign tx_squelch_out = {8{s_r.squelch}};

   // ==========================================
   // Checks
   a_lp_passes: assert property (@(posedge mclk_in) disable iff (rst_in) // see R5
      s_r.mst == state_low_power && !lp_cond |=> s_r.mst == state_powering_up)
      else $error("low power not left");
   a_lp_stops: assert property (@(posedge mclk_in) disable iff (rst_in) // see R1
      s_r.mst == state_low_power && lp_cond |=> s_r.mst == state_low_power)
      else $error("low power left while requested");
   a_ready_needs_hp: assert property (@(posedge mclk_in) disable iff (rst_in) // see R6
      s_r.mst == state_operational |-> s_r.hp)
      else $error("ready without high power");
   a_pwrup_raises_hp: assert property (@(posedge mclk_in) disable iff (rst_in) // see R6
      s_r.mst == state_powering_up |=> s_r.hp)
      else $error("high power not raised");
   a_pwrup_dp_off: assert property (@(posedge mclk_in) disable iff (rst_in) // see R6
      s_r.mst == state_powering_up |-> s_r.dst == '0)
      else $error("data path active during power up");
   a_ready_flag: assert property (@(posedge mclk_in) disable iff (rst_in) // see R7
      s_r.mst == state_powering_up ##1 s_r.mst == state_operational |=> mod_flag)
      else $error("ready flag missing");
   a_dp_start: assert property (@(posedge mclk_in) disable iff (rst_in) // see R8
      s_r.mst == state_operational && s_r.dst[0] == dp_state_off && !lp_cond
      && !s_r.deinit_mask[0] |=> s_r.dst[0] == dp_state_setting_up)
      else $error("data path did not start");
   a_cfg_loaded: assert property (@(posedge mclk_in) disable iff (rst_in) // see R9
      s_r.dst[0] == dp_state_prepared |-> s_r.dp_cfg == s_r.active_cfg)
      else $error("data path config not from active set");

   // Data path steps, flag clears and power-on defaults
   a_dp_init_done: assert property (@(posedge mclk_in) disable iff (rst_in) // see R9
      s_r.dst[0] == dp_state_setting_up && s_r.cnt == 8'h00 && all_setting && !lp_cond
      && !s_r.deinit_mask[0] |=> s_r.dst[0] == dp_state_prepared)
      else $error("data path not prepared");
   a_dp_tx_go: assert property (@(posedge mclk_in) disable iff (rst_in) // see R10
      s_r.dst[0] == dp_state_prepared && all_prepared && !dp_deactivate_cond
      && !s_r.deinit_mask[0] |=> s_r.dst[0] == dp_state_tx_enabling)
      else $error("data path did not go to tx enabling");
   a_tx_enabling: assert property (@(posedge mclk_in) disable iff (rst_in) // see R11
      s_r.dst[0] == dp_state_tx_enabling |=> s_r.tx_en[0])
      else $error("tx not enabled while enabling");
   a_tx_before_on: assert property (@(posedge mclk_in) disable iff (rst_in) // see R11
      s_r.dst[0] == dp_state_on |-> s_r.tx_en[0])
      else $error("tx not enabled in on");
   a_on_flag: assert property (@(posedge mclk_in) disable iff (rst_in) // see R12
      $rose(s_r.dst[0] == dp_state_on) |-> dp_flag[0])
      else $error("data path flag missing");
   a_on_holds: assert property (@(posedge mclk_in) disable iff (rst_in) // see R12
      s_r.dst[0] == dp_state_on && !dp_deactivate_cond && !s_r.deinit_mask[0]
      |=> s_r.dst[0] == dp_state_on)
      else $error("data path left on without cause");
   a_mod_read_clears: assert property (@(posedge mclk_in) disable iff (rst_in) // see R13
      rd_in && addr_in == OFS_MOD_FLAGS && !ev.mod_evt |=> !mod_flag)
      else $error("module flag not cleared by read");
   a_dp_read_clears: assert property (@(posedge mclk_in) disable iff (rst_in) // see R13
      rd_in && addr_in == OFS_DP_FLAGS && dp_enter_on == 8'h00 |=> dp_flag == 8'h00)
      else $error("data path flags not cleared by read");
   a_defaults: assert property (@(posedge mclk_in) // see R3
      $fell(rst_in) |-> s_r.hw_allow && !s_r.sw_lp && s_r.deinit_mask == 8'h00)
      else $error("power on defaults wrong");
endmodule : module_hw_init_sequencer
`default_nettype wire

/* File: test/host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Host side of the module: pins and interrupt watch
module host_model (
   input  wire logic       mclk_in,
   input  wire logic       lp_req_in,
   input  wire logic       irq_in,
   output logic            hw_low_power_pin_out,
   output logic            module_select_pin_out,
   output logic            host_tx_valid_out,
   output logic      [3:0] irq_rises_out
);
   // Known pin levels before the first edge
   logic       pin_r      = 1'b0;
   logic       tx_valid_r = 1'b0;
   logic       irq_q      = 1'b1;
   logic [3:0] rises_r    = 4'h0;

   // Module always selected
   assign module_select_pin_out = 1'b1;
   assign hw_low_power_pin_out  = pin_r;
   assign host_tx_valid_out     = tx_valid_r;
   assign irq_rises_out         = rises_r;

   // Pin follows the host's wish; host lanes valid early; count interrupt rises
   always @(posedge mclk_in) begin
      pin_r      <= lp_req_in;
      tx_valid_r <= 1'b1;
      irq_q      <= irq_in;
      if (irq_in === 1'b1 && irq_q === 1'b0) begin
         rises_r <= rises_r + 4'h1;
      end
   end
endmodule : host_model
`default_nettype wire

/* File: test/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Self-checking bench for the init sequencer
module testbench
   import seq_pkg::*;
;
   logic       mclk_in = 1'b0;
   logic       rst_in  = 1'b1;
   logic       lp_req  = 1'b0;
   logic       wr      = 1'b0;
   logic       rd      = 1'b0;
   logic [7:0] addr    = 8'h00;
   logic [7:0] wdata   = 8'h00;
   logic [7:0] rdata;
   logic       irq;
   logic       hp;
   logic       lp_pin;
   logic       sel_pin;
   logic       host_tx;
   logic [7:0] tx_en;
   logic [7:0] tx_sq;
   logic [3:0] irq_rises;
   int         fail_count   = 0;
   int         total_checks = 0;
   int         pin_v;
   int         ctrl_v;
   int         cpin[4] = '{0, 1, 1, 1};
   int         cctl[4] = '{2, 2, 0, 1};

   // Clock at 200 MHz
   always #2.5 mclk_in = ~mclk_in;

   host_model host (.mclk_in(mclk_in), .lp_req_in(lp_req), .irq_in(irq),
      .hw_low_power_pin_out(lp_pin), .module_select_pin_out(sel_pin),
      .host_tx_valid_out(host_tx), .irq_rises_out(irq_rises));

   module_hw_init_sequencer dut (.mclk_in(mclk_in), .rst_in(rst_in),
      .hw_low_power_pin_in(lp_pin), .module_select_pin_in(sel_pin), .addr_in(addr),
      .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .irq_out(irq),
      .high_power_out(hp), .tx_enable_out(tx_en), .tx_squelch_out(tx_sq));

   // ==========================================
   // Compare, bus cycles, expectations
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_in);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge mclk_in);
      wr    <= 1'b0;
   endtask : bus_wr

   task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
      @(posedge mclk_in);
      rd   <= 1'b1;
      addr <= a;
      @(posedge mclk_in);
      rd   <= 1'b0;
      #1;
      chk(name, exp, rdata);
   endtask : rd_chk

   task automatic wait_irq(input int limit);
      int n;
      n = 0;
      while (irq !== 1'b1 && n < limit) begin
         @(posedge mclk_in);
         #1;
         n++;
      end
      chk("irq raised", 8'h01, {7'h00, irq});
   endtask : wait_irq

   // Mode field expected after a control write in low power
   function automatic logic [7:0] exp_state(input int pin, input int ctrl);
      if (pin == 0) begin
         return 8'h02;
      end
      return (ctrl[0] || (ctrl[1] && pin != 0)) ? 8'h01 : 8'h02;
   endfunction : exp_state

   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : close_out

   // ==========================================
   // Hang guard
   initial begin
      repeat (5000) @(posedge mclk_in);
      fail_count++;
      close_out();
   end

   // ==========================================
   // Main sequence
   initial begin
      void'($urandom(8));
      repeat (12) @(posedge mclk_in);
      chk("host tx valid", 8'h01, {7'h00, host_tx});
      chk("module select", 8'h01, {7'h00, sel_pin});
      rst_in <= 1'b0;
      // Hardware start-up: powering up, then ready
      repeat (30) @(posedge mclk_in);
      rd_chk("state pwrup", OFS_STATE, 8'h02);
      chk("high power", 8'h01, {7'h00, hp});
      chk("tx off", 8'h00, tx_en);
      wait_irq(100);
      rd_chk("control", OFS_CONTROL, RST_CONTROL);
      rd_chk("deinit", OFS_DEINIT, 8'h00);
      rd_chk("tx ctrl", OFS_TX_CTRL, 8'h00);
      rd_chk("mod mask", OFS_MOD_MASK, 8'h00);
      rd_chk("active cfg", OFS_ACTIVE_CFG, DEFAULT_CFG);
      bus_wr(OFS_ACTIVE_CFG, 8'hA5);
      rd_chk("active ro", OFS_ACTIVE_CFG, DEFAULT_CFG);
      rd_chk("staged cfg", OFS_STAGED_CFG, DEFAULT_CFG);
      bus_wr(8'h0F, 8'h5A);
      rd_chk("unmapped", 8'h0F, 8'h00);
      $display("test defaults done");
      // Mask hides the flag, unmask shows it again, read clears it
      bus_wr(OFS_MOD_MASK, 8'h01);
      #1;
      chk("irq masked", 8'h00, {7'h00, irq});
      bus_wr(OFS_MOD_MASK, 8'h00);
      #1;
      chk("irq held", 8'h01, {7'h00, irq});
      rd_chk("mod flag", OFS_MOD_FLAGS, 8'h01);
      chk("irq cleared", 8'h00, {7'h00, irq});
      rd_chk("mod flag gone", OFS_MOD_FLAGS, 8'h00);
      $display("test module flag done");
      // Data paths run to on, second interrupt
      wait_irq(100);
      chk("tx on", 8'hFF, tx_en);
      rd_chk("state on", OFS_STATE, 8'h13);
      rd_chk("dp flags", OFS_DP_FLAGS, 8'hFF);
      chk("irq dp cleared", 8'h00, {7'h00, irq});
      chk("irq rises", 8'h03, {4'h0, irq_rises});
      bus_wr(OFS_TX_CTRL, 8'h02);
      @(posedge mclk_in);
      #1;
      chk("squelch", 8'hFF, tx_sq);
      // Tx disable drops outputs and parks paths in prepared; release re-arms
      bus_wr(OFS_TX_CTRL, 8'h01);
      @(posedge mclk_in);
      #1;
      chk("tx disabled", 8'h00, tx_en);
      chk("squelch off", 8'h00, tx_sq);
      rd_chk("state prepared", OFS_STATE, 8'h0B);
      bus_wr(OFS_TX_CTRL, 8'h00);
      wait_irq(100);
      chk("tx on again", 8'hFF, tx_en);
      rd_chk("dp flags again", OFS_DP_FLAGS, 8'hFF);
      $display("test data path done");
      // Low-power stop or pass-through, corners then random
      for (int t = 0; t < 8; t++) begin
         pin_v  = (t < 4) ? cpin[t] : int'($urandom % 2);
         ctrl_v = (t < 4) ? cctl[t] : int'($urandom % 4);
         @(posedge mclk_in);
         lp_req <= pin_v[0];
         rst_in <= 1'b1;
         repeat (3) @(posedge mclk_in);
         rst_in <= 1'b0;
         repeat (28) @(posedge mclk_in);
         rd_chk("mode after setup", OFS_STATE, (pin_v != 0) ? 8'h01 : 8'h02);
         bus_wr(OFS_CONTROL, ctrl_v[7:0]);
         repeat (2) @(posedge mclk_in);
         rd_chk("mode after ctrl", OFS_STATE, exp_state(pin_v, ctrl_v));
         $display("test low power trial %0d done", t);
      end
      close_out();
   end
endmodule : testbench
`default_nettype wire
